// ==== design/rtc_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none

module rtc_ctl
  import rtc_ctl_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire io_req_t IO_REQ,
  output logic [7:0] IO_RDATA,
  input wire logic UPDATE_TICK,
  input wire logic [14:0] DIV_TAPS,
  input wire logic ALARM1_HIT,
  input wire logic ALARM2_HIT,
  input wire logic CONTENTS_VALID,
  output logic IRQ,
  output time_t TIME_NOW,
  output logic [7:0] MODE_NOW
);

  state_t st_r;
  state_t st_nxt;

  // Binary value to byte in the selected data format
  function automatic logic [7:0] to_fmt(input logic [6:0] v,
                                        input logic bin);
    logic [7:0] r;
    r = bin ? {1'b0, v} : {4'(v / 7'd10), 4'(v % 7'd10)};
    return r;
  endfunction : to_fmt

  // Byte in the selected data format back to binary
  function automatic logic [6:0] from_fmt(input logic [7:0] d,
                                          input logic bin);
    logic [6:0] r;
    r = bin ? d[6:0] :
        7'({3'h0, d[7:4]} * 7'd10 + {3'h0, d[3:0]});
    return r;
  endfunction : from_fmt

  // Days in a month, leap years every fourth year
  function automatic logic [4:0] month_days(input logic [3:0] m,
                                            input logic [6:0] y);
    logic [4:0] r;
    case (m)
      4'h2: r = (y[1:0] == 2'h0) ? 5'd29 : 5'd28;
      4'h4, 4'h6, 4'h9, 4'hB: r = 5'd30;
      default: r = 5'd31;
    endcase
    return r;
  endfunction : month_days

  // Divider stage picked by a rate select code
  function automatic logic [3:0] tap_of(input logic [3:0] code);
    logic [3:0] r;
    case (code)
      4'h1: r = 4'h7;
      4'h2: r = 4'h8;
      default: r = 4'(code - 4'h1);
    endcase
    return r;
  endfunction : tap_of

  logic bin_fmt;
  logic h24;
  logic clock_off;
  logic [3:0] rate;
  logic tap_now;
  logic [4:0] hour12;
  logic [7:0] hour_byte;
  logic [7:0] read_val;
  logic [6:0] wr_bin;
  logic [6:0] wr_hour12;
  logic [4:0] wr_hour;

  // Decoded mode and divider settings
  always_comb begin
    bin_fmt = st_r.clock_mode_control[MODE_BINARY_FORMAT_SELECT];
    h24 = st_r.clock_mode_control[MODE_HOUR_24_SELECT];
    clock_off = (st_r.divider_control[DIV_CHAIN_LSB +: 3] == DIV_CHAIN_OFF)
      || (st_r.divider_control[DIV_CHAIN_LSB + 1 +: 2]
          == DIV_CHAIN_RESET_TOP);
    rate = st_r.divider_control[RATE_SELECT_LSB +: 4];
    tap_now = (rate != RATE_NONE) && DIV_TAPS[tap_of(rate)];
  end

  // Hour byte, 12-hour form carries PM in bit 7
  always_comb begin
    if (st_r.now.hour == 5'd0) begin
      hour12 = 5'd12;
    end else if (st_r.now.hour > 5'd12) begin
      hour12 = st_r.now.hour - 5'd12;
    end else begin
      hour12 = st_r.now.hour;
    end
    if (h24) begin
      hour_byte = to_fmt({2'h0, st_r.now.hour}, bin_fmt);
    end else begin
      hour_byte = to_fmt({2'h0, hour12}, bin_fmt);
      hour_byte[7] = (st_r.now.hour >= 5'd12);
    end
  end

  // Read mux for the data port
  always_comb begin
    case (st_r.index)
      IDX_SEC: read_val = to_fmt({1'b0, st_r.now.sec}, bin_fmt);
      IDX_MIN: read_val = to_fmt({1'b0, st_r.now.min}, bin_fmt);
      IDX_HOUR: read_val = hour_byte;
      IDX_DOW: read_val = to_fmt({4'h0, st_r.now.dow}, bin_fmt);
      IDX_DOM: read_val = to_fmt({2'h0, st_r.now.dom}, bin_fmt);
      IDX_MONTH: read_val = to_fmt({3'h0, st_r.now.month}, bin_fmt);
      IDX_YEAR: read_val = to_fmt(st_r.now.year, bin_fmt);
      IDX_DIVIDER_CONTROL: read_val = {1'b0, st_r.divider_control};
      IDX_CLOCK_MODE_CONTROL: read_val = st_r.clock_mode_control;
      IDX_CLOCK_INTERRUPT_FLAGS: read_val = {st_r.flags, 3'h0};
      IDX_POWER_VALID_REGISTER: read_val = {CONTENTS_VALID, 7'h00};
      default: read_val = 8'h00;
    endcase
  end

  // Written byte converted to binary, hour to 24-hour
  always_comb begin
    wr_bin = from_fmt(IO_REQ.wdata, bin_fmt);
    wr_hour12 = from_fmt({1'b0, IO_REQ.wdata[6:0]}, bin_fmt);
    if (h24) begin
      wr_hour = wr_bin[4:0];
    end else begin
      wr_hour = (wr_hour12 == 7'd12) ? 5'd0 : wr_hour12[4:0];
      if (IO_REQ.wdata[7]) begin
        wr_hour = wr_hour + 5'd12;
      end
    end
  end

  // Next state: update cycle, events, port access, forced clears
  always_comb begin
    logic do_update;
    logic in_dst_hour;
    logic rd_flags;
    logic per_ev;
    flags_t f;
    do_update = 1'b0;
    in_dst_hour = 1'b0;
    rd_flags = 1'b0;
    per_ev = 1'b0;
    f = st_r.flags;
    st_nxt = st_r;
    st_nxt.tap_prev = tap_now;

    // One second step per tick unless frozen or stopped
    do_update = UPDATE_TICK && !clock_off
      && !st_r.clock_mode_control[MODE_UPDATE_FREEZE];
    if (do_update) begin
      if (st_r.now.hour != 5'd1) begin
        st_nxt.fall_back_done = 1'b0;
      end
      if (st_r.now.sec != 6'd59) begin
        st_nxt.now.sec = st_r.now.sec + 6'd1;
      end else begin
        st_nxt.now.sec = 6'd0;
        if (st_r.now.min != 6'd59) begin
          st_nxt.now.min = st_r.now.min + 6'd1;
        end else begin
          st_nxt.now.min = 6'd0;
          if (st_r.now.hour != 5'd23) begin
            st_nxt.now.hour = st_r.now.hour + 5'd1;
          end else begin
            st_nxt.now.hour = 5'd0;
            st_nxt.now.dow = (st_r.now.dow >= 3'd7) ? 3'd1 :
                             st_r.now.dow + 3'd1;
            if (st_r.now.dom < month_days(st_r.now.month,
                                          st_r.now.year)) begin
              st_nxt.now.dom = st_r.now.dom + 5'd1;
            end else begin
              st_nxt.now.dom = 5'd1;
              if (st_r.now.month < 4'd12) begin
                st_nxt.now.month = st_r.now.month + 4'd1;
              end else begin
                st_nxt.now.month = 4'd1;
                st_nxt.now.year = (st_r.now.year >= 7'd99) ? 7'd0 :
                                  st_r.now.year + 7'd1;
              end
            end
          end
        end
      end
      // Daylight saving edges at 1:59:59 on a Sunday
      in_dst_hour = st_r.clock_mode_control[MODE_DAYLIGHT_SAVING_ENABLE]
        && st_r.now.hour == 5'd1 && st_r.now.min == 6'd59
        && st_r.now.sec == 6'd59 && st_r.now.dow == SUNDAY;
      if (in_dst_hour && st_r.now.month == MONTH_APRIL
          && st_r.now.dom <= FIRST_WEEK_LAST_DAY) begin
        st_nxt.now.hour = 5'd3;
      end
      if (in_dst_hour && st_r.now.month == MONTH_OCTOBER
          && st_r.now.dom >= LAST_WEEK_FIRST_DAY
          && !st_r.fall_back_done) begin
        st_nxt.now.hour = 5'd1;
        st_nxt.fall_back_done = 1'b1;
      end
    end

    // Port access; a flag read clears, but new events still land
    if (IO_REQ.rd) begin
      st_nxt.rdata = (IO_REQ.addr == PORT_DATA) ? read_val : st_r.index;
      rd_flags = (IO_REQ.addr == PORT_DATA)
        && (st_r.index == IDX_CLOCK_INTERRUPT_FLAGS);
    end
    if (rd_flags) begin
      f = '0;
    end
    if (IO_REQ.wr && IO_REQ.addr == PORT_INDEX) begin
      st_nxt.index = IO_REQ.wdata;
    end else if (IO_REQ.wr) begin
      case (st_r.index)
        IDX_SEC: st_nxt.now.sec = wr_bin[5:0];
        IDX_MIN: st_nxt.now.min = wr_bin[5:0];
        IDX_HOUR: st_nxt.now.hour = wr_hour;
        IDX_DOW: st_nxt.now.dow = wr_bin[2:0];
        IDX_DOM: st_nxt.now.dom = wr_bin[4:0];
        IDX_MONTH: st_nxt.now.month = wr_bin[3:0];
        IDX_YEAR: st_nxt.now.year = wr_bin;
        IDX_DIVIDER_CONTROL: st_nxt.divider_control = IO_REQ.wdata[6:0];
        IDX_CLOCK_MODE_CONTROL: st_nxt.clock_mode_control = IO_REQ.wdata;
        default: st_nxt.index = st_r.index;
      endcase
    end

    // Event sets win over the read clear
    per_ev = tap_now && !st_r.tap_prev;
    f.periodic_event_flag = f.periodic_event_flag | per_ev;
    f.update_done_flag = f.update_done_flag | do_update;
    f.alarm_one_flag = f.alarm_one_flag | ALARM1_HIT;
    f.alarm_two_flag = f.alarm_two_flag | ALARM2_HIT;

    // Hardware clears while stopped or contents invalid
    if (clock_off) begin
      f.periodic_event_flag = 1'b0;
      f.update_done_flag = 1'b0;
      st_nxt.clock_mode_control[MODE_PERIODIC_IRQ_ENABLE] = 1'b0;
      st_nxt.clock_mode_control[MODE_UPDATE_DONE_IRQ_ENABLE] = 1'b0;
    end
    if (!CONTENTS_VALID) begin
      f.alarm_one_flag = 1'b0;
      f.alarm_two_flag = 1'b0;
      st_nxt.clock_mode_control[MODE_ALARM_ONE_IRQ_ENABLE] = 1'b0;
      st_nxt.clock_mode_control[MODE_ALARM_TWO_IRQ_ENABLE] = 1'b0;
    end

    // Summary from the periodic, alarm one and update flags and enables that stand next cycle
    f.summary_irq_flag = f.summary_irq_flag
      | (f.periodic_event_flag
         & st_nxt.clock_mode_control[MODE_PERIODIC_IRQ_ENABLE])
      | (f.alarm_one_flag
         & st_nxt.clock_mode_control[MODE_ALARM_ONE_IRQ_ENABLE])
      | (f.update_done_flag
         & st_nxt.clock_mode_control[MODE_UPDATE_DONE_IRQ_ENABLE]);
    if (clock_off) begin
      f.summary_irq_flag = 1'b0;
    end
    st_nxt.flags = f;
  end

  // State register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_r.index <= INDEX_RESET;
      st_r.clock_mode_control <= MODE_RESET;
      st_r.divider_control <= DIVIDER_CONTROL_RESET;
      st_r.flags <= '0;
      st_r.now <= '0;
      st_r.fall_back_done <= 1'b0;
      st_r.tap_prev <= 1'b0;
      st_r.rdata <= TIME_FIELD_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign IO_RDATA = st_r.rdata;
  assign IRQ = st_r.flags.summary_irq_flag;
  assign TIME_NOW = st_r.now;
  assign MODE_NOW = st_r.clock_mode_control;

endmodule : rtc_ctl

`default_nettype wire

// ==== design/rtc_ctl_pkg.sv ====
package rtc_ctl_pkg;

  // Index values seen through the index port
  localparam logic [7:0] IDX_SEC = 8'h00;
  localparam logic [7:0] IDX_MIN = 8'h02;
  localparam logic [7:0] IDX_HOUR = 8'h04;
  localparam logic [7:0] IDX_DOW = 8'h06;
  localparam logic [7:0] IDX_DOM = 8'h07;
  localparam logic [7:0] IDX_MONTH = 8'h08;
  localparam logic [7:0] IDX_YEAR = 8'h09;
  localparam logic [7:0] IDX_DIVIDER_CONTROL = 8'h0A;
  localparam logic [7:0] IDX_CLOCK_MODE_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_CLOCK_INTERRUPT_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_POWER_VALID_REGISTER = 8'h0D;

  // Port select: low address bit, index port at 70h, data port at 71h
  localparam logic PORT_INDEX = 1'b0;
  localparam logic PORT_DATA = 1'b1;

  // Mode control bit positions
  localparam int MODE_UPDATE_FREEZE = 7;
  localparam int MODE_PERIODIC_IRQ_ENABLE = 6;
  localparam int MODE_ALARM_ONE_IRQ_ENABLE = 5;
  localparam int MODE_UPDATE_DONE_IRQ_ENABLE = 4;
  localparam int MODE_ALARM_TWO_IRQ_ENABLE = 3;
  localparam int MODE_BINARY_FORMAT_SELECT = 2;
  localparam int MODE_HOUR_24_SELECT = 1;
  localparam int MODE_DAYLIGHT_SAVING_ENABLE = 0;

  // Divider control field positions
  localparam int DIV_CHAIN_LSB = 4;
  localparam int RATE_SELECT_LSB = 0;
  localparam logic [2:0] DIV_CHAIN_NORMAL = 3'h2;
  localparam logic [2:0] DIV_CHAIN_OFF = 3'h0;
  localparam logic [1:0] DIV_CHAIN_RESET_TOP = 2'h3;
  localparam logic [3:0] RATE_NONE = 4'h0;

  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [6:0] DIVIDER_CONTROL_RESET = 7'h20;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] TIME_FIELD_RESET = 8'h00;

  // Calendar constants
  localparam logic [2:0] SUNDAY = 3'h1;
  localparam logic [3:0] MONTH_APRIL = 4'h4;
  localparam logic [3:0] MONTH_OCTOBER = 4'hA;
  localparam logic [4:0] FIRST_WEEK_LAST_DAY = 5'h07;
  localparam logic [4:0] LAST_WEEK_FIRST_DAY = 5'h19;

  // Software port request
  typedef struct packed {
    logic addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_t;

  // Event flags as laid out in bits 7..3 of the flag register
  typedef struct packed {
    logic summary_irq_flag;
    logic periodic_event_flag;
    logic alarm_one_flag;
    logic update_done_flag;
    logic alarm_two_flag;
  } flags_t;

  // Time of day and date, held in plain binary, 24-hour
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] dom;
    logic [2:0] dow;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } time_t;

  // Whole state of the control block
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] clock_mode_control;
    logic [6:0] divider_control;
    flags_t flags;
    time_t now;
    logic fall_back_done;
    logic tap_prev;
    logic [7:0] rdata;
  } state_t;

endpackage : rtc_ctl_pkg

// ==== test/rtc_ctl_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_ctl_checker
  import rtc_ctl_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire io_req_t IO_REQ,
  input wire logic [7:0] IO_RDATA,
  input wire logic UPDATE_TICK,
  input wire logic [14:0] DIV_TAPS,
  input wire logic ALARM1_HIT,
  input wire logic CONTENTS_VALID,
  input wire logic IRQ,
  input wire time_t TIME_NOW,
  input wire logic [7:0] MODE_NOW
);
  logic [7:0] idx_r;
  logic [2:0] chain_r;
  logic on;
  logic dwr;
  logic frd;
  // Shadow copy of the index and the divider chain field
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      idx_r <= INDEX_RESET;
      chain_r <= DIV_CHAIN_NORMAL;
    end else if (IO_REQ.wr && IO_REQ.addr == PORT_INDEX) begin
      idx_r <= IO_REQ.wdata;
    end else if (dwr && idx_r == IDX_DIVIDER_CONTROL) begin
      chain_r <= IO_REQ.wdata[6:4];
    end
  end
  // Clock running, data write and flag read decodes
  assign on = chain_r != DIV_CHAIN_OFF && chain_r[2:1] != DIV_CHAIN_RESET_TOP;
  assign dwr = IO_REQ.wr && IO_REQ.addr == PORT_DATA;
  assign frd = IO_REQ.rd && IO_REQ.addr == PORT_DATA
    && idx_r == IDX_CLOCK_INTERRUPT_FLAGS;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence s_tick;
    UPDATE_TICK && on && !IO_REQ.wr && !MODE_NOW[7];
  endsequence
  sequence s_quiet_read;
    frd && !UPDATE_TICK && !ALARM1_HIT && $stable(DIV_TAPS);
  endsequence
  a_freeze_holds_time: assert property (
    UPDATE_TICK && MODE_NOW[7] && !IO_REQ.wr |=> TIME_NOW == $past(TIME_NOW))
    else $error("time moved while frozen");
  a_tick_moves_sec: assert property (
    s_tick |=> TIME_NOW.sec != $past(TIME_NOW.sec))
    else $error("seconds did not advance");
  a_update_sets_irq: assert property (
    s_tick ##0 MODE_NOW[4] |=> IRQ) else $error("update irq missing");
  a_clock_off_enables: assert property (
    !on |=> !MODE_NOW[6] && !MODE_NOW[4])
    else $error("enables kept while clock off");
  a_invalid_alarm_off: assert property (
    !CONTENTS_VALID |=> !MODE_NOW[5] && !MODE_NOW[3])
    else $error("alarm enables kept while invalid");
  a_alarm_one_irq: assert property (
    ALARM1_HIT && on && CONTENTS_VALID && MODE_NOW[5] && !IO_REQ.wr
      |=> IRQ)
    else $error("alarm one irq missing");
  a_irq_needs_enable: assert property (
    $rose(IRQ) |-> |MODE_NOW[6:4]) else $error("irq without enable");
  a_read_clears_irq: assert property (
    s_quiet_read |=> !IRQ && IO_RDATA[2:0] == 3'h0)
    else $error("flag read did not clear");
  a_mode_format: assert property (
    dwr && idx_r == IDX_CLOCK_MODE_CONTROL
      |=> MODE_NOW[2:0] == $past(IO_REQ.wdata[2:0]))
    else $error("format bits not stored");
endmodule : rtc_ctl_checker
bind rtc_ctl rtc_ctl_checker rtc_ctl_checker_i (.SYS_CLK(SYS_CLK),
  .RST(RST), .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA),
  .UPDATE_TICK(UPDATE_TICK), .DIV_TAPS(DIV_TAPS), .ALARM1_HIT(ALARM1_HIT),
  .CONTENTS_VALID(CONTENTS_VALID), .IRQ(IRQ), .TIME_NOW(TIME_NOW),
  .MODE_NOW(MODE_NOW));
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
  import rtc_ctl_pkg::*;
;
  logic SYS_CLK, RST, UPDATE_TICK, ALARM1_HIT, ALARM2_HIT, CONTENTS_VALID;
  io_req_t IO_REQ;
  logic [7:0] IO_RDATA, MODE_NOW, rd_v;
  logic [14:0] DIV_TAPS;
  logic IRQ;
  time_t TIME_NOW;
  int failures, checked, tap;
  localparam logic [7:0] FLG = IDX_CLOCK_INTERRUPT_FLAGS;
  localparam logic [7:0] MOD = IDX_CLOCK_MODE_CONTROL;
  rtc_ctl rtc_ctl_i (.SYS_CLK(SYS_CLK), .RST(RST), .IO_REQ(IO_REQ),
    .IO_RDATA(IO_RDATA), .UPDATE_TICK(UPDATE_TICK), .DIV_TAPS(DIV_TAPS),
    .ALARM1_HIT(ALARM1_HIT), .ALARM2_HIT(ALARM2_HIT),
    .CONTENTS_VALID(CONTENTS_VALID), .IRQ(IRQ), .TIME_NOW(TIME_NOW),
    .MODE_NOW(MODE_NOW));
  // Clock
  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  // Compare and count
  task automatic check(input string n, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // One port access, read data taken the cycle after
  task automatic io(input logic a, w, input logic [7:0] d);
    @(negedge SYS_CLK);
    IO_REQ = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge SYS_CLK);
    IO_REQ = '0;
    rd_v = IO_RDATA;
  endtask : io
  task automatic wreg(input logic [7:0] i, d);
    io(PORT_INDEX, 1'b1, i);
    io(PORT_DATA, 1'b1, d);
  endtask : wreg
  task automatic rchk(input string n, input logic [7:0] i, e);
    io(PORT_INDEX, 1'b1, i);
    io(PORT_DATA, 1'b0, 8'h00);
    check(n, rd_v, e);
  endtask : rchk
  // One-cycle event pulses: bit 0 tick, bit 1 alarm one, bit 2 alarm two
  task automatic ev(input logic [2:0] k);
    @(negedge SYS_CLK);
    {ALARM2_HIT, ALARM1_HIT, UPDATE_TICK} = k;
    @(negedge SYS_CLK);
    {ALARM2_HIT, ALARM1_HIT, UPDATE_TICK} = 3'h0;
  endtask : ev
  // Sunday 1:59:59 in the given month and day, then one update
  task automatic dst(input logic [7:0] mon, dom, hr);
    wreg(IDX_MONTH, mon);
    wreg(IDX_DOM, dom);
    wreg(IDX_DOW, 8'h01);
    wreg(IDX_HOUR, 8'h01);
    wreg(IDX_MIN, 8'h3B);
    wreg(IDX_SEC, 8'h3B);
    ev(3'h1);
    check("dst hour", TIME_NOW.hour, hr);
    check("dst min", TIME_NOW.min, 16'h0);
  endtask : dst
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // Hang guard
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
  // Main sequence
  initial begin
    failures = 0;
    checked = 0;
    IO_REQ = '0;
    {ALARM2_HIT, ALARM1_HIT, UPDATE_TICK} = 3'h0;
    CONTENTS_VALID = 1'b1;
    DIV_TAPS = '0;
    RST = 1'b1;
    repeat (10) @(negedge SYS_CLK);
    RST = 1'b0;
    rchk("mode rst", MOD, 8'h00);
    rchk("flags rst", FLG, 8'h00);
    wreg(FLG, 8'hFF);
    rchk("flags ro", FLG, 8'h00);
    rchk("unmapped", 8'h01, 8'h00);
    $display("reset test done");
    wreg(MOD, 8'h06);
    wreg(IDX_SEC, 8'h3B);
    wreg(IDX_HOUR, 8'h0D);
    wreg(MOD, 8'h02);
    rchk("sec bcd", IDX_SEC, 8'h59);
    wreg(MOD, 8'h04);
    rchk("hour 12h", IDX_HOUR, 8'h81);
    wreg(IDX_HOUR, 8'h8C);
    check("hour pm wr", TIME_NOW.hour, 16'hC);
    $display("format test done");
    wreg(MOD, 8'h16);
    wreg(IDX_SEC, 8'h05);
    ev(3'h1);
    check("irq", IRQ, 16'h1);
    check("sec", TIME_NOW.sec, 16'h6);
    rchk("flags upd", FLG, 8'h90);
    rchk("flags clr", FLG, 8'h00);
    wreg(MOD, 8'h96);
    ev(3'h1);
    check("frozen", TIME_NOW.sec, 16'h6);
    rchk("flags frz", FLG, 8'h00);
    $display("update test done");
    wreg(MOD, 8'h40);
    for (int c = 0; c < 16; c++) begin
      DIV_TAPS = '0;
      wreg(IDX_DIVIDER_CONTROL, {4'h2, c[3:0]});
      tap = (c == 1) ? 7 : (c == 2) ? 8 : c - 1;
      DIV_TAPS = (c == 0) ? 15'h7FFF : 15'h0001 << tap;
      rchk("periodic", FLG, (c == 0) ? 8'h00 : 8'hC0);
    end
    $display("periodic test done");
    wreg(MOD, 8'h50);
    ev(3'h1);
    wreg(IDX_DIVIDER_CONTROL, 8'h00);
    rchk("mode off", MOD, 8'h00);
    rchk("flags off", FLG, 8'h00);
    wreg(MOD, 8'h50);
    rchk("mode off wr", MOD, 8'h00);
    wreg(IDX_DIVIDER_CONTROL, 8'h20);
    $display("clock off test done");
    wreg(MOD, 8'h28);
    ev(3'h2);
    rchk("alarm1", FLG, 8'hA0);
    ev(3'h4);
    rchk("alarm2", FLG, 8'h08);
    CONTENTS_VALID = 1'b0;
    ev(3'h6);
    rchk("mode inv", MOD, 8'h00);
    rchk("flags inv", FLG, 8'h00);
    rchk("valid bit", IDX_POWER_VALID_REGISTER, 8'h00);
    CONTENTS_VALID = 1'b1;
    rchk("valid set", IDX_POWER_VALID_REGISTER, 8'h80);
    $display("alarm test done");
    wreg(MOD, 8'h07);
    dst(8'h04, 8'h01, 8'h03);
    dst(8'h0A, 8'h19, 8'h01);
    dst(8'h0A, 8'h19, 8'h02);
    $display("daylight test done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
